// ==== bsie_defs.svh ====
// constants for the bit, shift and pair inc/dec execution unit
// assumes one T state per enabled clock (200 MHz, 5 ns)
// Operation
// - pair increment, no flags, 6 T states
// - pair decrement, no flags, 6 T states
// - any pair or index register; indexed 10 T
// - set bit in register, 8 T
// - clear bit in register, 8 T
// - test register bit, zero flag, 8 T
// - test: Z inverse, H set, N reset
// - prefix then op, bit, selector fields
// - selector 110 uses pointer memory, 15 T
// - indexed: prefix, CB, displacement, op; 23 T
// - memory test reads only, sets zero flag
// - rotate right keeps S Z PV; 4 T
// - left shift opcode 00100 r, 8 T
// - left shift flags, carry from bit 7
// - right shift register, write back
// - right shift flags, carry from bit 0
`ifndef BSIE_DEFS_SVH
`define BSIE_DEFS_SVH

// ----------------------------------------
// opcodes and fields
// ----------------------------------------
`define BSIE_OP_IDX_A 8'hdd
`define BSIE_OP_IDX_B 8'hfd
`define BSIE_OP_CB 8'hcb
`define BSIE_OP_ROT_ACC 8'h1f
`define BSIE_PAIR_LOW 3'h3
`define BSIE_MEM_SEL 3'h6
`define BSIE_GRP_SHIFT 2'h0
`define BSIE_GRP_TEST 2'h1
`define BSIE_GRP_CLR 2'h2
`define BSIE_GRP_SET 2'h3
`define BSIE_SH_LEFT 3'h4
`define BSIE_SH_RIGHT 3'h5
`define BSIE_PP_PTR 2'h2

// ----------------------------------------
// flag bits and register indices
// ----------------------------------------
`define BSIE_FL_S 7
`define BSIE_FL_Z 6
`define BSIE_FL_H 4
`define BSIE_FL_PV 2
`define BSIE_FL_N 1
`define BSIE_FL_C 0
`define BSIE_RI_F 4'h6
`define BSIE_RI_A 4'h7
`define BSIE_RI_STK 4'h8
`define BSIE_RI_XA 4'ha
`define BSIE_RI_XB 4'hc
`define BSIE_RI_PCH 4'he
`define BSIE_RI_PCL 4'hf
`define BSIE_RF_RESET 8'h00

// ----------------------------------------
// instruction lengths in T states
// ----------------------------------------
`define BSIE_T_PAIR 5'd6
`define BSIE_T_PAIR_IDX 5'd10
`define BSIE_T_BIT_REG 5'd8
`define BSIE_T_BIT_PTR 5'd15
`define BSIE_T_BIT_IDX 5'd23
`define BSIE_T_ROT_ACC 5'd4
`define BSIE_T_ILLEGAL 5'd4

`endif

// ==== bsie_exec.sv ====
// execution unit: pair inc/dec, bit set/clear/test, shifts, rotate acc right
// assumes program/data memory on the same clock, read data one cycle after rd
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "bsie_defs.svh"

module bsie_exec (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic run,
  output bsie_pkg::bsie_mem_req_type mem_req,
  input wire logic [7:0] mem_rdata,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic instr_done,
  output logic illegal_op,
  output logic busy,
  output logic [7:0] flags
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic parity_even(input logic [7:0] v);
    parity_even = ~(^v);
  endfunction

  // returns {result, flags}
  function automatic logic [15:0] cb_alu(input logic [7:0] op, input logic [7:0] d, input logic [7:0] f);
    logic [7:0] r;
    logic [7:0] nf;
    r = d;
    nf = f;
    case (op[7:6])
      `BSIE_GRP_TEST: begin
        nf[`BSIE_FL_Z] = ~d[op[5:3]];
        nf[`BSIE_FL_H] = 1'b1;
        nf[`BSIE_FL_N] = 1'b0;
      end
      `BSIE_GRP_CLR: r = d & ~(8'h01 << op[5:3]);
      `BSIE_GRP_SET: r = d | (8'h01 << op[5:3]);
      default: begin
        if (op[5:3] == `BSIE_SH_LEFT) begin
          r = {d[6:0], 1'b0};
          nf[`BSIE_FL_C] = d[7];
        end else begin
          r = {d[7], d[7:1]};
          nf[`BSIE_FL_C] = d[0];
        end
        nf[`BSIE_FL_S] = r[7];
        nf[`BSIE_FL_Z] = (r == 8'h00);
        nf[`BSIE_FL_PV] = parity_even(r);
        nf[`BSIE_FL_H] = 1'b0;
        nf[`BSIE_FL_N] = 1'b0;
      end
    endcase
    cb_alu = {r, nf};
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] rf_q [0:13];
  logic [15:0] pc_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] op_q;
  logic [7:0] disp_q;
  logic idx_q;
  logic sel_q;
  logic cb_q;
  logic dgot_q;
  logic oper_q;
  logic ill_pend_q;
  logic [4:0] tcnt_q;
  logic [4:0] tot_q;
  logic done_q;
  logic ill_q;
  bsie_pkg::bsie_state_type state_q;
  bsie_pkg::bsie_kind_type kind;

  logic [7:0] b;
  logic [15:0] ptr_w;
  logic [15:0] xr_w;
  logic [15:0] ea_w;
  assign b = mem_rdata;
  assign ptr_w = {rf_q[4], rf_q[5]};
  assign xr_w = sel_q ? {rf_q[`BSIE_RI_XB], rf_q[`BSIE_RI_XB + 4'h1]} : {rf_q[`BSIE_RI_XA], rf_q[`BSIE_RI_XA + 4'h1]};
  assign ea_w = idx_q ? xr_w + {{8{disp_q[7]}}, disp_q} : ptr_w;

  // ----------------------------------------
  // decode of the byte arriving from memory
  // ----------------------------------------
  always_comb begin
    kind = bsie_pkg::K_NONE;
    if (state_q == bsie_pkg::ST_BYTE) begin
      if (oper_q) begin
        kind = bsie_pkg::K_OPERAND;
      end else if (cb_q) begin
        if (idx_q && !dgot_q) begin
          kind = bsie_pkg::K_DISP;
        end else if (b[2:0] == `BSIE_MEM_SEL) begin
          // memory forms of the shifts are not handled here
          kind = (b[7:6] == `BSIE_GRP_SHIFT) ? bsie_pkg::K_ILL : bsie_pkg::K_CB_MEM;
        end else if (idx_q || (b[7:6] == `BSIE_GRP_SHIFT && b[5:3] != `BSIE_SH_LEFT && b[5:3] != `BSIE_SH_RIGHT)) begin
          kind = bsie_pkg::K_ILL;
        end else begin
          kind = bsie_pkg::K_CB_REG;
        end
      end else if ((b == `BSIE_OP_IDX_A || b == `BSIE_OP_IDX_B) && !idx_q) begin
        kind = bsie_pkg::K_PFX_IDX;
      end else if (b == `BSIE_OP_CB) begin
        kind = bsie_pkg::K_PFX_CB;
      end else if (b == `BSIE_OP_ROT_ACC && !idx_q) begin
        kind = bsie_pkg::K_ROT_ACC;
      end else if (b[7:6] == 2'h0 && b[2:0] == `BSIE_PAIR_LOW && (!idx_q || b[5:4] == `BSIE_PP_PTR)) begin
        kind = bsie_pkg::K_INCDEC;
      end else begin
        kind = bsie_pkg::K_ILL;
      end
    end
  end

  // ----------------------------------------
  // execute: register file write requests
  // ----------------------------------------
  logic [7:0] alu_op;
  logic [7:0] alu_in;
  logic [15:0] alu;
  logic [3:0] ph;
  logic [15:0] p16;
  logic [15:0] pn;
  logic we8;
  logic [3:0] i8;
  logic [7:0] v8;
  logic wep;
  logic wef;
  logic [7:0] fv;

  always_comb begin
    alu_op = (kind == bsie_pkg::K_OPERAND) ? op_q : b;
    alu_in = (kind == bsie_pkg::K_OPERAND) ? mem_rdata : rf_q[{1'b0, b[2:0]}];
    alu = cb_alu(alu_op, alu_in, rf_q[`BSIE_RI_F]);
    case (b[5:4])
      2'h0: ph = 4'h0;
      2'h1: ph = 4'h2;
      2'h2: ph = idx_q ? (sel_q ? `BSIE_RI_XB : `BSIE_RI_XA) : 4'h4;
      default: ph = `BSIE_RI_STK;
    endcase
    p16 = {rf_q[ph], rf_q[ph + 4'h1]};
    pn = b[3] ? p16 - 16'h0001 : p16 + 16'h0001;
    we8 = 1'b0;
    i8 = {1'b0, b[2:0]};
    v8 = alu[15:8];
    wep = 1'b0;
    wef = 1'b0;
    fv = alu[7:0];
    case (kind)
      bsie_pkg::K_CB_REG: begin
        we8 = (b[7:6] != `BSIE_GRP_TEST);
        wef = 1'b1;
      end
      bsie_pkg::K_OPERAND: wef = (op_q[7:6] == `BSIE_GRP_TEST);
      bsie_pkg::K_INCDEC: wep = 1'b1;
      bsie_pkg::K_ROT_ACC: begin
        we8 = 1'b1;
        i8 = `BSIE_RI_A;
        v8 = {rf_q[`BSIE_RI_F][`BSIE_FL_C], rf_q[`BSIE_RI_A][7:1]};
        wef = 1'b1;
        fv = rf_q[`BSIE_RI_F];
        fv[`BSIE_FL_C] = rf_q[`BSIE_RI_A][0];
        fv[`BSIE_FL_H] = 1'b0;
        fv[`BSIE_FL_N] = 1'b0;
      end
      default: ;
    endcase
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  // execution writes land after the software write, so they win a collision
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < 14; i++) begin
        rf_q[i] <= `BSIE_RF_RESET;
      end
    end else if (ce) begin
      if (reg_wr && reg_addr < `BSIE_RI_PCH) begin
        rf_q[reg_addr] <= reg_wdata;
      end
      if (we8) begin
        rf_q[i8] <= v8;
      end
      if (wep) begin
        rf_q[ph] <= pn[15:8];
        rf_q[ph + 4'h1] <= pn[7:0];
      end
      if (wef) begin
        rf_q[`BSIE_RI_F] <= fv;
      end
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= bsie_pkg::ST_IDLE;
      pc_q <= 16'h0000;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      op_q <= 8'h00;
      disp_q <= 8'h00;
      idx_q <= 1'b0;
      sel_q <= 1'b0;
      cb_q <= 1'b0;
      dgot_q <= 1'b0;
      oper_q <= 1'b0;
      ill_pend_q <= 1'b0;
      tcnt_q <= 5'd0;
      tot_q <= `BSIE_T_ILLEGAL;
      done_q <= 1'b0;
      ill_q <= 1'b0;
    end else if (ce) begin
      done_q <= 1'b0;
      ill_q <= 1'b0;
      if (reg_wr && reg_addr == `BSIE_RI_PCH) begin
        pc_q[15:8] <= reg_wdata;
      end
      if (reg_wr && reg_addr == `BSIE_RI_PCL) begin
        pc_q[7:0] <= reg_wdata;
      end
      if (tcnt_q != 5'd31) begin
        tcnt_q <= tcnt_q + 5'd1;
      end
      case (state_q)
        bsie_pkg::ST_IDLE: begin
          if (run) begin
            addr_q <= pc_q;
            pc_q <= pc_q + 16'h0001;
            tcnt_q <= 5'd0;
            {idx_q, cb_q, dgot_q, oper_q} <= 4'h0;
            state_q <= bsie_pkg::ST_RD;
          end
        end
        bsie_pkg::ST_RD: state_q <= bsie_pkg::ST_BYTE;
        bsie_pkg::ST_BYTE: begin
          state_q <= bsie_pkg::ST_WAIT;
          case (kind)
            bsie_pkg::K_PFX_IDX: begin
              idx_q <= 1'b1;
              sel_q <= b[5];
            end
            bsie_pkg::K_PFX_CB: cb_q <= 1'b1;
            bsie_pkg::K_DISP: begin
              disp_q <= b;
              dgot_q <= 1'b1;
            end
            bsie_pkg::K_CB_MEM: begin
              op_q <= b;
              oper_q <= 1'b1;
              addr_q <= ea_w;
              tot_q <= idx_q ? `BSIE_T_BIT_IDX : `BSIE_T_BIT_PTR;
              state_q <= bsie_pkg::ST_RD;
            end
            bsie_pkg::K_OPERAND: begin
              if (op_q[7:6] != `BSIE_GRP_TEST) begin
                wdata_q <= alu[15:8];
                state_q <= bsie_pkg::ST_WR;
              end
            end
            bsie_pkg::K_CB_REG: tot_q <= `BSIE_T_BIT_REG;
            bsie_pkg::K_INCDEC: tot_q <= idx_q ? `BSIE_T_PAIR_IDX : `BSIE_T_PAIR;
            bsie_pkg::K_ROT_ACC: tot_q <= `BSIE_T_ROT_ACC;
            default: begin
              tot_q <= `BSIE_T_ILLEGAL;
              ill_pend_q <= 1'b1;
            end
          endcase
          if (kind == bsie_pkg::K_PFX_IDX || kind == bsie_pkg::K_PFX_CB || kind == bsie_pkg::K_DISP) begin
            addr_q <= pc_q;
            pc_q <= pc_q + 16'h0001;
            state_q <= bsie_pkg::ST_RD;
          end
        end
        bsie_pkg::ST_WR: state_q <= bsie_pkg::ST_WAIT;
        bsie_pkg::ST_WAIT: begin
          // pad to the documented length; >= covers illegal bytes after long prefixes
          if (tcnt_q >= tot_q - 5'd1) begin
            done_q <= 1'b1;
            ill_q <= ill_pend_q;
            ill_pend_q <= 1'b0;
            if (run) begin
              addr_q <= pc_q;
              pc_q <= pc_q + 16'h0001;
              tcnt_q <= 5'd0;
              {idx_q, cb_q, dgot_q, oper_q} <= 4'h0;
              state_q <= bsie_pkg::ST_RD;
            end else begin
              state_q <= bsie_pkg::ST_IDLE;
            end
          end
        end
        default: state_q <= bsie_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // software read port
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (ce && reg_rd) begin
      if (reg_addr == `BSIE_RI_PCH) begin
        reg_rdata <= pc_q[15:8];
      end else if (reg_addr == `BSIE_RI_PCL) begin
        reg_rdata <= pc_q[7:0];
      end else begin
        reg_rdata <= rf_q[reg_addr];
      end
    end
  end

  // one driver for the whole request word
  assign mem_req = {state_q == bsie_pkg::ST_RD, state_q == bsie_pkg::ST_WR, addr_q, wdata_q};
  assign instr_done = done_q;
  assign illegal_op = ill_q;
  assign busy = (state_q != bsie_pkg::ST_IDLE);
  assign flags = rf_q[`BSIE_RI_F];

endmodule // bsie_exec

// ==== bsie_exec_sva.sv ====
// port checks for the execution unit
// assumes one clock domain and the synchronous active-high reset
`timescale 1ns/1ps
module bsie_exec_sva (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic run,
  input wire bsie_pkg::bsie_mem_req_type mem_req,
  input wire logic [7:0] mem_rdata,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic instr_done,
  input wire logic illegal_op,
  input wire logic busy,
  input wire logic [7:0] flags
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ------
  // memory strobes, read-modify-write, done spacing, flag and read port checks
  // ------
  sequence s_rmw;
    mem_req.rd ##2 mem_req.wr;
  endsequence
  sequence s_done;
    instr_done && ce;
  endsequence
  rd_one_cycle_a: assert property (mem_req.rd && ce |=> !mem_req.rd)
    else $error("memory read strobe held too long");
  rd_wr_apart_a: assert property (!(mem_req.rd && mem_req.wr))
    else $error("memory read and write together");
  wr_after_read_a: assert property (mem_req.wr |-> $past(mem_req.rd, 2))
    else $error("memory write without operand read");
  rmw_same_addr_a: assert property (s_rmw |-> mem_req.addr == $past(mem_req.addr, 2))
    else $error("write address differs from operand address");
  rmw_one_bit_a: assert property (s_rmw |-> $countones(mem_req.wdata ^ $past(mem_rdata)) <= 1)
    else $error("write back changes more than one bit");
  done_spacing_a: assert property (s_done |=> !instr_done [*3])
    else $error("instructions shorter than four T states");
  illegal_done_a: assert property (illegal_op |-> instr_done)
    else $error("illegal flag outside instruction end");
  flags_quiet_a: assert property ($changed(flags) |-> $past(busy) || $past(reg_wr))
    else $error("flags changed while idle");
  freeze_hold_a: assert property (!ce |=> $stable(mem_req) && $stable(flags) && $stable(reg_rdata))
    else $error("state moved while clock enable low");
  rdata_quiet_a: assert property ($changed(reg_rdata) |-> $past(reg_rd))
    else $error("read port changed without read");
endmodule // bsie_exec_sva

bind bsie_exec bsie_exec_sva bsie_exec_sva_inst (.clk(clk), .reset(reset), .ce(ce), .run(run), .mem_req(mem_req),
  .mem_rdata(mem_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .instr_done(instr_done), .illegal_op(illegal_op), .busy(busy), .flags(flags));

// ==== bsie_mem_model.sv ====
// behavioural program and data memory for the execution unit
// assumes the unit's timing: read data in the cycle after rd, no wait states
`timescale 1ns/1ps
module bsie_mem_model (
  input wire logic clk,
  input wire logic ce,
  input wire bsie_pkg::bsie_mem_req_type mem_req,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  initial mem_rdata = 8'h00;
  // ------
  // array
  // ------
  // data stand only after rd; the rest of the time they toggle, so a late sample misreads
  always @(posedge clk) begin
    if (ce) begin
      mem_rdata <= mem_req.rd ? mem[mem_req.addr] : ~mem_rdata;
      if (mem_req.wr) begin
        mem[mem_req.addr] <= mem_req.wdata;
      end
    end
  end
endmodule // bsie_mem_model

// ==== bsie_pkg.sv ====
// types for the bit, shift and pair inc/dec execution unit
// constants live in bsie_defs.svh
package bsie_pkg;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } bsie_mem_req_type;

  typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_BYTE, ST_WR, ST_WAIT} bsie_state_type;

  typedef enum logic [3:0] {
    K_NONE, K_PFX_IDX, K_PFX_CB, K_DISP, K_CB_REG, K_CB_MEM, K_OPERAND, K_INCDEC, K_ROT_ACC, K_ILL
  } bsie_kind_type;

endpackage

// ==== tb_top.sv ====
// self-checking bench for the execution unit with a behavioural memory
// assumes PC 0 after reset; instructions are laid down from address 0
`timescale 1ns/1ps
`include "bsie_defs.svh"
module tb_top;
  logic clk;
  logic ce = 1'b1;
  logic reset = 1'b1, run = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic instr_done, illegal_op, busy;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, flags, mem_rdata, d;
  logic [15:0] pc = 16'h0000, v;
  bsie_pkg::bsie_mem_req_type mem_req;
  int n_fail = 0, tests_run = 0, cyc = 0, nwr = 0;

  bsie_exec bsie_exec_inst (.clk(clk), .reset(reset), .ce(ce), .run(run), .mem_req(mem_req),
    .mem_rdata(mem_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .instr_done(instr_done), .illegal_op(illegal_op), .busy(busy), .flags(flags));
  bsie_mem_model bsie_mem_model_inst (.clk(clk), .ce(ce), .mem_req(mem_req), .mem_rdata(mem_rdata));

  // ------
  // clock, watchdog, bus tasks
  // ------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (mem_req.wr === 1'b1) begin
      nwr <= nwr + 1;
    end
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] x);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= x;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [7:0] x);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    x = reg_rdata;
  endtask
  task automatic wpair(input logic [3:0] ri, input logic [15:0] x);
    wreg(ri, x[15:8]);
    wreg(ri + 4'h1, x[7:0]);
  endtask
  task automatic rpair(input logic [3:0] ri, output logic [15:0] x);
    rreg(ri, x[15:8]);
    rreg(ri + 4'h1, x[7:0]);
  endtask
  task automatic put(input logic [7:0] b);
    bsie_mem_model_inst.mem[pc] = b;
    pc++;
  endtask
  // one instruction: run until the first fetch, then count T states to the done pulse
  task automatic exec(input int t, input logic ill);
    int n = 0;
    @(posedge clk);
    run <= 1'b1;
    while (mem_req.rd !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk("busy_run", 16'h0001, 16'(busy));
    run <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (instr_done !== 1'b1 && n < 40);
    chk("t_states", 16'(t), 16'(n));
    chk("illegal", 16'(ill), 16'(illegal_op));
    chk("busy_idle", 16'h0000, 16'(busy));
  endtask

  // ------
  // scenarios
  // ------
  task automatic t_reset();
    rreg(`BSIE_RI_A, d);
    chk("acc_reset", 8'h00, d);
    chk("flags_reset", 8'h00, flags);
  endtask
  // clock enable low: a write must not land and the read port must hold
  task automatic t_freeze();
    wreg(`BSIE_RI_A, 8'h11);
    rreg(`BSIE_RI_A, d);
    @(posedge clk);
    ce <= 1'b0;
    wreg(`BSIE_RI_A, 8'h22);
    rreg(`BSIE_RI_F, d);
    chk("frozen_read", 8'h11, d);
    @(posedge clk);
    ce <= 1'b1;
    rreg(`BSIE_RI_A, d);
    chk("frozen_write", 8'h11, d);
  endtask
  task automatic t_pair();
    logic [3:0] ri;
    for (int k = 0; k < 8; k++) begin
      ri = (k % 4 == 3) ? `BSIE_RI_STK : 4'(2 * (k % 4));
      wreg(`BSIE_RI_F, 8'hd7);
      wpair(ri, 16'h00ff);
      put(8'h03 + 8'(k / 4 * 8) + 8'(k % 4 * 16));
      exec(`BSIE_T_PAIR, 1'b0);
      rpair(ri, v);
      chk("pair", k < 4 ? 16'h0100 : 16'h00fe, v);
      chk("pair_flags", 8'hd7, flags);
    end
    wpair(`BSIE_RI_XA, 16'hffff);
    wpair(`BSIE_RI_XB, 16'h0000);
    put(`BSIE_OP_IDX_A);
    put(8'h23);
    exec(`BSIE_T_PAIR_IDX, 1'b0);
    put(`BSIE_OP_IDX_B);
    put(8'h2b);
    exec(`BSIE_T_PAIR_IDX, 1'b0);
    rpair(`BSIE_RI_XA, v);
    chk("first_index", 16'h0000, v);
    rpair(`BSIE_RI_XB, v);
    chk("second_index", 16'hffff, v);
  endtask
  task automatic t_bitreg();
    logic [7:0] x, e;
    for (int r = 0; r < 8; r++) begin
      for (int op = 1; op < 4 && r != 6; op++) begin
        x = 8'h5a ^ 8'(r);
        wreg(4'(r), x);
        wreg(`BSIE_RI_F, 8'h03);
        put(`BSIE_OP_CB);
        put({2'(op), 3'(r), 3'(r)});
        exec(`BSIE_T_BIT_REG, 1'b0);
        e = op == 3 ? x | (8'h01 << r) : op == 2 ? x & ~(8'h01 << r) : x;
        rreg(4'(r), d);
        chk("bit_reg", e, d);
        chk("bit_flags", op == 1 ? {1'b0, ~x[r], 6'h11} : 8'h03, flags & (op == 1 ? 8'h53 : 8'hff));
      end
    end
  endtask
  task automatic t_bitmem();
    logic [15:0] a;
    logic [7:0] m, e;
    int op, w;
    wpair(`BSIE_RI_XA, 16'h0300);
    wpair(`BSIE_RI_XB, 16'h0400);
    wpair(4'h4, 16'h0200);
    for (int k = 0; k < 9; k++) begin
      op = k % 3 + 1;
      a = k < 3 ? 16'h0200 : k < 6 ? 16'h0305 : 16'h0405;
      m = op == 2 ? 8'hff : op == 3 ? 8'h00 : 8'ha5;
      bsie_mem_model_inst.mem[a] = m;
      wreg(`BSIE_RI_F, 8'h03);
      w = nwr;
      if (k >= 3) begin
        put(k < 6 ? `BSIE_OP_IDX_A : `BSIE_OP_IDX_B);
      end
      put(`BSIE_OP_CB);
      if (k >= 3) begin
        put(8'h05);
      end
      put({2'(op), 3'(k), `BSIE_MEM_SEL});
      exec(k < 3 ? `BSIE_T_BIT_PTR : `BSIE_T_BIT_IDX, 1'b0);
      e = op == 3 ? m | (8'h01 << k % 8) : op == 2 ? m & ~(8'h01 << k % 8) : m;
      chk("bit_mem", e, bsie_mem_model_inst.mem[a]);
      chk("mem_writes", 16'(op != 1), 16'(nwr - w));
      if (op == 1) begin
        chk("test_flags", {1'b0, ~m[k % 8], 6'h11}, flags & 8'h53);
      end
    end
  endtask
  task automatic t_alu(input logic [7:0] pfx, input logic [7:0] opc, input logic [3:0] ri, input logic [7:0] x,
      input logic [7:0] ex, input logic [7:0] f, input logic [7:0] ef);
    wreg(ri, x);
    wreg(`BSIE_RI_F, f);
    if (pfx !== 8'h00) begin
      put(pfx);
    end
    put(opc);
    exec(pfx !== 8'h00 ? `BSIE_T_BIT_REG : `BSIE_T_ROT_ACC, 1'b0);
    rreg(ri, d);
    chk("result", ex, d);
    chk("alu_flags", ef, flags & 8'hd7);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_freeze();
    t_pair();
    t_bitreg();
    t_bitmem();
    t_alu(8'h00, `BSIE_OP_ROT_ACC, `BSIE_RI_A, 8'h81, 8'h40, 8'hd6, 8'hc5);
    t_alu(8'h00, `BSIE_OP_ROT_ACC, `BSIE_RI_A, 8'h02, 8'h81, 8'h01, 8'h00);
    t_alu(`BSIE_OP_CB, 8'h20, 4'h0, 8'h81, 8'h02, 8'h12, 8'h01);
    t_alu(`BSIE_OP_CB, 8'h21, 4'h1, 8'h80, 8'h00, 8'h12, 8'h45);
    t_alu(`BSIE_OP_CB, 8'h2a, 4'h2, 8'h81, 8'hc0, 8'h12, 8'h85);
    t_alu(`BSIE_OP_CB, 8'h2f, `BSIE_RI_A, 8'h40, 8'h20, 8'h12, 8'h00);
    put(8'h00);
    exec(`BSIE_T_ILLEGAL, 1'b1);
    // shift kind 110 is refused; the used prefix stretches the no-op by one T
    put(`BSIE_OP_CB);
    put(8'h30);
    exec(`BSIE_T_ILLEGAL + 5'd1, 1'b1);
    final_report();
  end
endmodule // tb_top
